// File: hw/osc_stop_pkg.sv
// package: register map, field layouts and constants of the clock fallback block
package osc_stop_pkg;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_SYS_DIV = 8'h00;
    localparam logic [7:0] OFF_CLK_SRC = 8'h04;
    localparam logic [7:0] OFF_PLL_CTRL = 8'h08;
    localparam logic [7:0] OFF_MAIN_OSC = 8'h0c;
    localparam logic [7:0] OFF_SUP_CTRL = 8'h10;
    localparam logic [7:0] OFF_SUP_STAT = 8'h14;
    localparam logic [7:0] OFF_NMI_EN = 8'h18;

    // ----------------------------------------
    // field positions and widths
    // ----------------------------------------
    localparam int SRC_W = 3;
    localparam int PLL_W = 16;
    localparam int MAIN_OSC_STOP_POS = 0;
    localparam int SUP_ENABLE_POS = 0;
    localparam int STOP_FLAG_POS = 0;
    localparam int NMI_OSC_EN_POS = 0;

    // ----------------------------------------
    // clock sources
    // ----------------------------------------
    typedef enum logic [SRC_W-1:0] {
        SRC_LOW_SPEED = 3'h0,
        SRC_HIGH_SPEED = 3'h1,
        SRC_MAIN_OSC = 3'h2,
        SRC_SUB_OSC = 3'h3,
        SRC_PLL = 3'h4
    } clk_src_t;

    // one 32-bit divider word, all fields updated by one write
    typedef struct packed {
        logic [3:0] flashDiv;
        logic [3:0] coreDiv;
        logic [3:0] reservedHi;
        logic [3:0] busDiv;
        logic [3:0] periphADiv;
        logic [3:0] periphBDiv;
        logic [7:0] reservedLo;
    } sys_div_t;

    // apb request as seen by the slave
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } apb_req_t;

    // ----------------------------------------
    // reset values and constants
    // ----------------------------------------
    localparam logic [31:0] SYS_DIV_RESET = 32'h0000_0000;
    localparam logic [PLL_W-1:0] PLL_RESET = 16'h0000;
    localparam logic MAIN_OSC_STOP_RESET = 1'b1;
    localparam int LOW_SPEED_KHZ = 125;
    localparam logic [1:0] ROM_RAM_CYCLES = 2'h1;
    localparam logic [6:0] FLASH_WAIT_MAX = 7'h40;

endpackage : osc_stop_pkg

// File: hw/osc_stop_fallback.sv
// clock source selection with main oscillator stop supervision and fallback
//
// The register addresses and the APB slave port are this design's own decisions.
module osc_stop_fallback (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mainOscStopped,
    output osc_stop_pkg::clk_src_t sysClkSource,
    output osc_stop_pkg::sys_div_t sysDividers,
    output logic [osc_stop_pkg::PLL_W-1:0] pllSetting,
    output logic mainOscStop,
    output logic oscStopNmi,
    output logic rtcMainFeedValid,
    output logic watchdogClkRun,
    output logic [6:0] dataFlashWait,
    output logic [1:0] romRamCycles
);

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    osc_stop_pkg::apb_req_t req;
    logic setupPhase;
    logic accessPhase;
    logic wrStrobe;
    logic mapped;

    // address check is used for the error answer and for the write strobe
    function automatic logic is_mapped(input logic [7:0] a);
        if (a == osc_stop_pkg::OFF_SYS_DIV) return 1'b1;
        else if (a == osc_stop_pkg::OFF_CLK_SRC) return 1'b1;
        else if (a == osc_stop_pkg::OFF_PLL_CTRL) return 1'b1;
        else if (a == osc_stop_pkg::OFF_MAIN_OSC) return 1'b1;
        else if (a == osc_stop_pkg::OFF_SUP_CTRL) return 1'b1;
        else if (a == osc_stop_pkg::OFF_SUP_STAT) return 1'b1;
        else if (a == osc_stop_pkg::OFF_NMI_EN) return 1'b1;
        else return 1'b0;
    endfunction

    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
    assign setupPhase = req.sel && !req.enable;
    assign accessPhase = req.sel && req.enable;
    assign mapped = is_mapped(req.addr);
    // writes land only at the completing edge of the access phase
    assign wrStrobe = accessPhase && req.write && mapped;
    // zero wait states: read data is fetched during setup
    assign pready = 1'b1;
    assign pslverr = accessPhase && !mapped;

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    // named enables keep each next-state line down to one condition
    logic wrSysDiv;
    logic wrClkSrc;
    logic wrPll;
    logic wrMainOsc;
    logic wrSupCtrl;
    logic wrSupStat;
    logic wrNmiEn;

    // only mapped access cycles can raise an enable
    assign wrSysDiv = wrStrobe && req.addr == osc_stop_pkg::OFF_SYS_DIV;
    assign wrClkSrc = wrStrobe && req.addr == osc_stop_pkg::OFF_CLK_SRC;
    assign wrPll = wrStrobe && req.addr == osc_stop_pkg::OFF_PLL_CTRL;
    assign wrMainOsc = wrStrobe && req.addr == osc_stop_pkg::OFF_MAIN_OSC;
    assign wrSupCtrl = wrStrobe && req.addr == osc_stop_pkg::OFF_SUP_CTRL;
    assign wrSupStat = wrStrobe && req.addr == osc_stop_pkg::OFF_SUP_STAT;
    assign wrNmiEn = wrStrobe && req.addr == osc_stop_pkg::OFF_NMI_EN;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // software-visible state; narrow fields sit in the low bits of their word
    logic [31:0] sysDivReg;
    logic [31:0] sysDivNext;
    logic [osc_stop_pkg::SRC_W-1:0] srcFieldReg;
    logic [osc_stop_pkg::SRC_W-1:0] srcFieldNext;
    logic [osc_stop_pkg::PLL_W-1:0] pllReg;
    logic [osc_stop_pkg::PLL_W-1:0] pllNext;
    logic mainStopReg;
    logic mainStopNext;
    logic supEnableReg;
    logic supEnableNext;
    logic stopFlagReg;
    logic stopFlagNext;
    logic nmiEnableReg;
    logic nmiEnableNext;
    logic [31:0] rdataReg;
    logic [31:0] rdataNext;
    logic stopEvent;
    logic clearReq;
    logic srcIsLow;

    // one full-word write replaces every divider field at once
    assign sysDivNext = wrSysDiv ?
        req.wdata : sysDivReg;
    assign srcFieldNext = wrClkSrc ?
        req.wdata[osc_stop_pkg::SRC_W-1:0] : srcFieldReg;
    assign pllNext = wrPll ?
        req.wdata[osc_stop_pkg::PLL_W-1:0] : pllReg;
    assign mainStopNext = wrMainOsc ?
        req.wdata[osc_stop_pkg::MAIN_OSC_STOP_POS] : mainStopReg;
    assign supEnableNext = wrSupCtrl ?
        req.wdata[osc_stop_pkg::SUP_ENABLE_POS] : supEnableReg;
    assign nmiEnableNext = wrNmiEn ?
        req.wdata[osc_stop_pkg::NMI_OSC_EN_POS] : nmiEnableReg;

    // stop detection only counts while supervision is on
    assign stopEvent = supEnableReg && mainOscStopped;
    assign srcIsLow = srcFieldReg == osc_stop_pkg::SRC_LOW_SPEED;
    // a clear is writing zero; it is dropped unless low-speed is already chosen
    assign clearReq = wrSupStat && !req.wdata[osc_stop_pkg::STOP_FLAG_POS] &&
        srcIsLow;
    // detection wins over a clear in the same cycle so no stop is lost
    assign stopFlagNext = stopEvent ? 1'b1 : (clearReq ? 1'b0 : stopFlagReg);

    // read mux, registered in setup so prdata is a flop output
    // unmapped offsets read as zero, so probing the map is harmless
    assign rdataNext = !setupPhase ? rdataReg :
        (req.addr == osc_stop_pkg::OFF_SYS_DIV) ? sysDivReg :
        (req.addr == osc_stop_pkg::OFF_CLK_SRC) ? {29'h0, srcFieldReg} :
        (req.addr == osc_stop_pkg::OFF_PLL_CTRL) ? {16'h0, pllReg} :
        (req.addr == osc_stop_pkg::OFF_MAIN_OSC) ? {31'h0, mainStopReg} :
        (req.addr == osc_stop_pkg::OFF_SUP_CTRL) ? {31'h0, supEnableReg} :
        (req.addr == osc_stop_pkg::OFF_SUP_STAT) ? {31'h0, stopFlagReg} :
        (req.addr == osc_stop_pkg::OFF_NMI_EN) ? {31'h0, nmiEnableReg} : 32'h0;

    // register update, all state has a reset value
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sysDivReg <= osc_stop_pkg::SYS_DIV_RESET;
            srcFieldReg <= osc_stop_pkg::SRC_LOW_SPEED;
            pllReg <= osc_stop_pkg::PLL_RESET;
            mainStopReg <= osc_stop_pkg::MAIN_OSC_STOP_RESET;
            supEnableReg <= 1'b0;
            stopFlagReg <= 1'b0;
            nmiEnableReg <= 1'b0;
            rdataReg <= 32'h0;
        end else begin
            sysDivReg <= sysDivNext;
            srcFieldReg <= srcFieldNext;
            pllReg <= pllNext;
            mainStopReg <= mainStopNext;
            supEnableReg <= supEnableNext;
            stopFlagReg <= stopFlagNext;
            nmiEnableReg <= nmiEnableNext;
            rdataReg <= rdataNext;
        end
    end

    assign prdata = rdataReg;

    // ----------------------------------------
    // clock steering outputs
    // ----------------------------------------
    // limitation: only the chosen source code leaves here; the glitch-free mux is outside
    logic [osc_stop_pkg::SRC_W-1:0] srcSelNext;
    logic [osc_stop_pkg::SRC_W-1:0] srcSelReg;
    logic nmiReg;
    logic rtcValidReg;
    logic [6:0] flashWaitReg;
    logic [6:0] flashWaitNext;
    logic [3:0] flashDivField;

    // the flag overrides the select field; low-speed source runs at 125 kHz
    // steering from the raw event saves one cycle of running on a dead clock
    assign srcSelNext = (stopFlagReg || stopEvent) ? osc_stop_pkg::SRC_LOW_SPEED :
        srcFieldReg;
    assign flashDivField = sysDivReg[31:28];
    // data flash read wait grows with the flash clock divide ratio
    // beyond a divide step of six the wait simply saturates
    assign flashWaitNext = (flashDivField > 4'h6) ? osc_stop_pkg::FLASH_WAIT_MAX :
        7'(7'h1 << flashDivField);

    // outputs are flops; fallback never touches divider or pll state
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            srcSelReg <= osc_stop_pkg::SRC_LOW_SPEED;
            nmiReg <= 1'b0;
            rtcValidReg <= 1'b0;
            flashWaitReg <= 7'h1;
        end else begin
            srcSelReg <= srcSelNext;
            nmiReg <= stopFlagNext && nmiEnableReg;
            rtcValidReg <= !mainOscStopped && !mainStopReg;
            flashWaitReg <= flashWaitNext;
        end
    end

    assign sysClkSource = osc_stop_pkg::clk_src_t'(srcSelReg);
    assign sysDividers = sysDivReg;
    assign pllSetting = pllReg;
    assign mainOscStop = mainStopReg;
    assign oscStopNmi = nmiReg;
    // rtc feed stays tied to the main oscillator; it just goes invalid on a stop
    assign rtcMainFeedValid = rtcValidReg;
    // watchdog has its own oscillator, so the fallback never gates it
    assign watchdogClkRun = 1'b1;
    assign dataFlashWait = flashWaitReg;
    // rom and ram stay single cycle whatever the flash divider holds
    assign romRamCycles = osc_stop_pkg::ROM_RAM_CYCLES;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // reset and enable
    a_sup_off_default: assert property (!supEnableReg && !stopFlagReg |=> !stopFlagReg)
        else $error("stop flag set while supervision disabled");
    a_sup_needs_write: assert property (!supEnableReg && !wrSupCtrl |=> !supEnableReg)
        else $error("supervision enabled without a write");
    // reset lies outside the default disable, so this one names its own
    a_reset_defaults: assert property (@(posedge mclk) disable iff (1'b0)
        sys_rst |=> sysClkSource == osc_stop_pkg::SRC_LOW_SPEED && !supEnableReg)
        else $error("reset left a fast source or supervision on");

    // fallback and the stop flag
    a_stop_sets_flag: assert property (stopEvent |=> stopFlagReg)
        else $error("stop event did not set flag");
    a_fallback_source: assert property (
        stopEvent |=> sysClkSource == osc_stop_pkg::SRC_LOW_SPEED)
        else $error("no fallback to low-speed source");
    a_hold_low_flag: assert property (
        stopFlagReg |=> sysClkSource == osc_stop_pkg::SRC_LOW_SPEED)
        else $error("left low-speed source while flag set");
    // a refused clear must leave the flag alone
    a_clear_guard: assert property (
        stopFlagReg && !srcIsLow |=> stopFlagReg)
        else $error("flag cleared without low-speed selection");
    a_flag_sticky: assert property (stopFlagReg && !clearReq |=> stopFlagReg)
        else $error("flag dropped without clear");
    a_clear_drops: assert property (clearReq && !stopEvent |=> !stopFlagReg)
        else $error("accepted clear left the flag set");
    a_select_honoured: assert property (
        !stopFlagReg && !stopEvent |=> sysClkSource == $past(srcFieldReg))
        else $error("select field not honoured after clear");
    a_div_kept: assert property (
        stopEvent && !wrStrobe |=> $stable(sysDivReg) && $stable(pllReg))
        else $error("fallback altered divider or pll");

    // side effects: nmi, rtc feed and flash timing
    a_nmi_gated: assert property (
        oscStopNmi |-> $past(nmiEnableReg) && $past(stopFlagNext))
        else $error("nmi raised without enable");
    a_nmi_follows: assert property (stopEvent && nmiEnableReg |=> oscStopNmi)
        else $error("enabled nmi not raised on stop");
    a_nmi_masked: assert property (!nmiEnableReg |=> !oscStopNmi)
        else $error("masked nmi raised");
    // the feed is never steered, so a dead oscillator means no rtc clock
    a_rtc_no_fallback: assert property (mainOscStopped |=> !rtcMainFeedValid)
        else $error("rtc feed reported valid on a dead oscillator");
    a_flash_wait_cap: assert property (
        flashDivField > 4'h6 |=> dataFlashWait == osc_stop_pkg::FLASH_WAIT_MAX)
        else $error("flash wait not saturated");

    // bus view of the registers
    a_div_word: assert property (
        wrSysDiv |=> sysDivReg == $past(req.wdata))
        else $error("divider word not written whole");
    a_status_read: assert property (
        setupPhase && req.addr == osc_stop_pkg::OFF_SUP_STAT |=>
        prdata == {31'h0, $past(stopFlagReg)})
        else $error("status read does not show the flag");

    // scenarios the bench is expected to reach
    c_fallback: cover property (
        stopEvent ##1 stopFlagReg ##1 sysClkSource == osc_stop_pkg::SRC_LOW_SPEED);
    c_recovery: cover property (stopFlagReg ##1 clearReq ##1 !stopFlagReg);
    c_nmi: cover property (oscStopNmi);
    c_refused_clear: cover property (stopFlagReg && wrSupStat && !srcIsLow);
    c_pll_return: cover property (
        clearReq ##[1:100] sysClkSource == osc_stop_pkg::SRC_PLL);

endmodule // osc_stop_fallback

// File: test/tb_top.sv
// self-checking bench for the clock fallback block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin errTotal++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

    // ----------------------------------------
    // design ports and counters
    // ----------------------------------------
    logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, mainOscStopped;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    osc_stop_pkg::clk_src_t sysClkSource;
    osc_stop_pkg::sys_div_t sysDividers;
    logic [osc_stop_pkg::PLL_W-1:0] pllSetting;
    logic mainOscStop, oscStopNmi, rtcMainFeedValid, watchdogClkRun;
    logic [6:0] dataFlashWait;
    logic [1:0] romRamCycles;
    int errTotal = 0;
    int checkCount = 0;

    osc_stop_fallback DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mainOscStopped(mainOscStopped), .sysClkSource(sysClkSource),
        .sysDividers(sysDividers), .pllSetting(pllSetting), .mainOscStop(mainOscStop),
        .oscStopNmi(oscStopNmi), .rtcMainFeedValid(rtcMainFeedValid),
        .watchdogClkRun(watchdogClkRun), .dataFlashWait(dataFlashWait),
        .romRamCycles(romRamCycles));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // data flash wait doubles per divider step and saturates at 64
    function automatic logic [6:0] expWait(input logic [3:0] f);
        return (f > 4'h6) ? 7'h40 : (7'h01 << f);
    endfunction

    // one apb transfer; an idle edge follows so strobes never toggle twice per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // no wait-state count is assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    // write then confirm by reading back before any other clock register is touched
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
        apb(1'b0, a, 32'h0, rd, er);
        `CHK(rd, d)
    endtask

    task automatic testDone;
        $display("checks=%0d mismatches=%0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------
    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // the run needs well under 1000 cycles, so 4000 means a hang
    initial begin
        #20000;
        errTotal++;
        testDone;
    end

    // scenarios in order: reset, divider words, fallback with nmi, recovery, masked nmi
    initial begin : mainSeq
        logic [31:0] rd, d, pll;
        logic er;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mainOscStopped = 1'b1;
        void'($urandom(32'h8f6f3c8e));
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        `CHK(sysClkSource, osc_stop_pkg::SRC_LOW_SPEED)
        `CHK(watchdogClkRun, 1'b1)
        `CHK(romRamCycles, osc_stop_pkg::ROM_RAM_CYCLES)
        `CHK(mainOscStop, 1'b1)
        // detector reports a stop, but supervision is still off
        repeat (3) @(posedge mclk);
        apb(1'b0, osc_stop_pkg::OFF_SUP_CTRL, 32'h0, rd, er);
        `CHK(rd, 32'h0)
        apb(1'b0, osc_stop_pkg::OFF_SUP_STAT, 32'h0, rd, er);
        `CHK(rd, 32'h0)
        // whole divider words, first the documented example then random ones
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 32'h21021200 : ($urandom & 32'hff0fff00);
            wr(osc_stop_pkg::OFF_SYS_DIV, d);
            `CHK(sysDividers, d)
            `CHK(dataFlashWait, expWait(d[31:28]))
            `CHK(romRamCycles, osc_stop_pkg::ROM_RAM_CYCLES)
        end
        pll = $urandom & 32'h0000ffff;
        wr(osc_stop_pkg::OFF_PLL_CTRL, pll);
        wr(osc_stop_pkg::OFF_MAIN_OSC, 32'h0);
        mainOscStopped <= 1'b0;
        // let the oscillator settle before supervision may be enabled
        repeat (4) @(posedge mclk);
        `CHK(rtcMainFeedValid, 1'b1)
        wr(osc_stop_pkg::OFF_CLK_SRC, 32'(osc_stop_pkg::SRC_MAIN_OSC));
        `CHK(sysClkSource, osc_stop_pkg::SRC_MAIN_OSC)
        wr(osc_stop_pkg::OFF_NMI_EN, 32'h1);
        wr(osc_stop_pkg::OFF_SUP_CTRL, 32'h1);
        // main oscillator dies while supervised
        mainOscStopped <= 1'b1;
        repeat (3) @(posedge mclk);
        `CHK(sysClkSource, osc_stop_pkg::SRC_LOW_SPEED)
        `CHK(oscStopNmi, 1'b1)
        `CHK(rtcMainFeedValid, 1'b0)
        `CHK(sysDividers, d)
        `CHK(pllSetting, pll[15:0])
        `CHK(watchdogClkRun, 1'b1)
        apb(1'b0, osc_stop_pkg::OFF_SUP_STAT, 32'h0, rd, er);
        `CHK(rd, 32'h1)
        // pll request while flagged must not move the clock
        wr(osc_stop_pkg::OFF_CLK_SRC, 32'(osc_stop_pkg::SRC_PLL));
        `CHK(sysClkSource, osc_stop_pkg::SRC_LOW_SPEED)
        wr(osc_stop_pkg::OFF_SUP_CTRL, 32'h0);
        // clear attempt with pll still selected is ignored
        apb(1'b1, osc_stop_pkg::OFF_SUP_STAT, 32'h0, rd, er);
        apb(1'b0, osc_stop_pkg::OFF_SUP_STAT, 32'h0, rd, er);
        `CHK(rd, 32'h1)
        wr(osc_stop_pkg::OFF_CLK_SRC, 32'(osc_stop_pkg::SRC_LOW_SPEED));
        apb(1'b1, osc_stop_pkg::OFF_SUP_STAT, 32'h0, rd, er);
        apb(1'b0, osc_stop_pkg::OFF_SUP_STAT, 32'h0, rd, er);
        `CHK(rd, 32'h0)
        `CHK(oscStopNmi, 1'b0)
        wr(osc_stop_pkg::OFF_CLK_SRC, 32'(osc_stop_pkg::SRC_PLL));
        `CHK(sysClkSource, osc_stop_pkg::SRC_PLL)
        // random source codes are honoured once the flag is clear
        for (int i = 0; i < 4; i++) begin
            d = $urandom_range(4);
            wr(osc_stop_pkg::OFF_CLK_SRC, d);
            `CHK(sysClkSource, d[2:0])
        end
        // second stop with the nmi masked
        mainOscStopped <= 1'b0;
        wr(osc_stop_pkg::OFF_NMI_EN, 32'h0);
        wr(osc_stop_pkg::OFF_SUP_CTRL, 32'h1);
        mainOscStopped <= 1'b1;
        repeat (3) @(posedge mclk);
        `CHK(sysClkSource, osc_stop_pkg::SRC_LOW_SPEED)
        `CHK(oscStopNmi, 1'b0)
        // unmapped word answers with an error and reads zero
        apb(1'b1, 8'h3c, 32'hffffffff, rd, er);
        `CHK(er, 1'b1)
        apb(1'b0, 8'h3c, 32'h0, rd, er);
        `CHK(rd, 32'h0)
        testDone;
    end
endmodule // tb_top
